// >>> hdl/sdcp_top.sv
`timescale 1ns/1ns
`include "sdcp_defines.svh"
// Operation
// - Serial load high passes shift register; falling holds.
// - Shift data in on each shift clock rise.
// - Parallel load low follows pins; rise freezes.
// - Loop divider field is unsigned, bit 8 MSB.
// - Output select 00/01/10/11 divides 2/4/8/16.
// - Observation output chosen only by probe bits.
// - 16 MHz reference, divide two: 1 MHz steps.
// - Fourteen bits: probe, output select, loop, MSB first.
// - Parallel load beats serial load.
// - Parallel load low forces probe bits to zero.
// - Reference divided by eight for phase comparison.
module sdcp_top #(
  parameter int XTAL_KHZ = `SDCP_XTAL_KHZ,
  parameter int FREQ_W = `SDCP_FREQ_W
) (
  input wire logic i_ref_clk, // Reference clock, XTAL_KHZ kHz, 16 MHz by default.
  input wire logic i_sys_rst, // Asynchronous reset, active high.
  input wire logic i_shift_clk, // Serial shift clock from the host.
  input wire logic i_shift_data, // Serial data, sampled on shift clock rise.
  input wire logic i_serial_load, // Serial load strobe, latches open while high.
  input wire logic i_par_load_n, // Parallel load strobe, latches open while low.
  input wire sdcp_pkg::sdcp_m_t i_par_m, // Parallel loop divider value.
  input wire sdcp_pkg::sdcp_n_t i_par_n, // Parallel output divider select.
  output sdcp_pkg::sdcp_m_t o_loop_div, // Latched loop divider value.
  output sdcp_pkg::sdcp_n_t o_out_sel, // Latched output divider select.
  output logic [4:0] o_out_ratio, // Decoded output divide ratio.
  output sdcp_pkg::sdcp_t_t o_probe_sel, // Latched probe select.
  output logic o_fref, // Comparison reference, reference clock over eight.
  output logic o_synth_clock_out, // Emulated synthesizer output.
  output logic o_test, // Observation output.
  output logic [FREQ_W-1:0] o_synth_freq_khz // Nominal output frequency in kHz.
);
  import sdcp_pkg::*;

  // --------------------------------------------------------------------------
  // Shift clock domain
  // --------------------------------------------------------------------------
  logic [`SDCP_SR_LEN-1:0] sr_q;
  logic shift_tog_q;

  // Each rise shifts one bit in; the first bit walks up to the top.
  always_ff @(posedge i_shift_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      sr_q <= `SDCP_SR_RST;
      shift_tog_q <= 1'b0;
    end else begin
      sr_q <= {sr_q[`SDCP_SR_LEN-2:0], i_shift_data};
      shift_tog_q <= ~shift_tog_q;
    end
  end

  // --------------------------------------------------------------------------
  // Crossing into the reference domain
  // --------------------------------------------------------------------------
  // The shift word travels as a toggle event plus a word that is stable
  // by the time the toggle is seen; the shift clock is slower than three
  // reference periods, so the word cannot move while it is copied.
  logic [2:0] tog_sync_q;
  logic [1:0] sload_sync_q;
  logic [1:0] pload_n_sync_q;
  logic [8:0] m_s1_q;
  logic [8:0] m_s2_q;
  logic [1:0] n_s1_q;
  logic [1:0] n_s2_q;
  logic [`SDCP_SR_LEN-1:0] sr_copy_q;
  logic shift_seen;

  assign shift_seen = tog_sync_q[2] ^ tog_sync_q[1];

  // Pins pass two flops before any logic reads them.
  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      tog_sync_q <= 3'h0;
      sload_sync_q <= 2'h0;
      pload_n_sync_q <= 2'h0;
      m_s1_q <= `SDCP_M_RST;
      m_s2_q <= `SDCP_M_RST;
      n_s1_q <= `SDCP_N_RST;
      n_s2_q <= `SDCP_N_RST;
    end else begin
      tog_sync_q <= {tog_sync_q[1:0], shift_tog_q};
      sload_sync_q <= {sload_sync_q[0], i_serial_load};
      pload_n_sync_q <= {pload_n_sync_q[0], i_par_load_n};
      m_s1_q <= i_par_m;
      m_s2_q <= m_s1_q;
      n_s1_q <= i_par_n;
      n_s2_q <= n_s1_q;
    end
  end

  // Copy of the shift register, refreshed after every shift.
  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      sr_copy_q <= `SDCP_SR_RST;
    end else if (shift_seen) begin
      sr_copy_q <= sr_q;
    end
  end

  // --------------------------------------------------------------------------
  // Configuration latches
  // --------------------------------------------------------------------------
  // Modelled as registers that follow their source while open and hold
  // once closed. The parallel strobe is checked first so it always wins.
  logic par_open;
  logic ser_open;
  sdcp_m_t cfg_m_d;
  sdcp_n_t cfg_n_d;
  sdcp_t_t cfg_t_d;
  sdcp_m_t cfg_m_q;
  sdcp_n_t cfg_n_q;
  sdcp_t_t cfg_t_q;

  assign par_open = ~pload_n_sync_q[1];
  assign ser_open = sload_sync_q[1];
  assign cfg_m_d = par_open ? m_s2_q :
                   ser_open ? sr_copy_q[`SDCP_M_HI:`SDCP_M_LO] : cfg_m_q;
  assign cfg_n_d = par_open ? n_s2_q :
                   ser_open ? sr_copy_q[`SDCP_N_HI:`SDCP_N_LO] : cfg_n_q;
  assign cfg_t_d = par_open ? `SDCP_T_RST :
                   ser_open ? sr_copy_q[`SDCP_T_HI:`SDCP_T_LO] : cfg_t_q;

  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      cfg_m_q <= `SDCP_M_RST;
      cfg_n_q <= `SDCP_N_RST;
      cfg_t_q <= `SDCP_T_RST;
    end else begin
      cfg_m_q <= cfg_m_d;
      cfg_n_q <= cfg_n_d;
      cfg_t_q <= cfg_t_d;
    end
  end

  // --------------------------------------------------------------------------
  // Ratio decoding
  // --------------------------------------------------------------------------
  // Output select is a power of two: 2 shifted by the select.
  function automatic logic [4:0] sdcp_out_ratio(input sdcp_n_t sel);
    sdcp_out_ratio = 5'h02 << sel;
  endfunction

  logic [4:0] out_ratio;
  logic [8:0] out_ratio_w;
  logic [8:0] out4_ratio_w;
  logic [31:0] fref_khz;
  logic [31:0] freq_prod;
  logic [31:0] freq_khz;

  assign out_ratio = sdcp_out_ratio(cfg_n_q);
  assign out_ratio_w = {4'h0, out_ratio};
  assign out4_ratio_w = {2'h0, out_ratio, 2'h0};
  // Comparison reference is the crystal over eight; output is that times
  // the loop value over the output ratio, so a 16 MHz crystal with select
  // 00 steps the output by 1 MHz per unit of the loop value.
  assign fref_khz = XTAL_KHZ / 8;
  assign freq_prod = fref_khz * {23'h0, cfg_m_q};
  assign freq_khz = freq_prod >> ({30'h0, cfg_n_q} + 32'h1);

  // --------------------------------------------------------------------------
  // Dividers
  // --------------------------------------------------------------------------
  logic fref_div;
  logic mcnt_div;
  logic out_div;
  logic out4_div;

  sdcp_div #(.W(9)) u_fref_div (
    .i_clk(i_ref_clk),
    .i_rst(i_sys_rst),
    .i_ratio(`SDCP_REF_PREDIV),
    .o_div(fref_div)
  );

  sdcp_div #(.W(9)) u_mcnt_div (
    .i_clk(i_ref_clk),
    .i_rst(i_sys_rst),
    .i_ratio(cfg_m_q),
    .o_div(mcnt_div)
  );

  sdcp_div #(.W(9)) u_out_div (
    .i_clk(i_ref_clk),
    .i_rst(i_sys_rst),
    .i_ratio(out_ratio_w),
    .o_div(out_div)
  );

  // Output divided once more by four for the slow observation path.
  sdcp_div #(.W(9)) u_out4_div (
    .i_clk(i_ref_clk),
    .i_rst(i_sys_rst),
    .i_ratio(out4_ratio_w),
    .o_div(out4_div)
  );

  // --------------------------------------------------------------------------
  // Observation output selection
  // --------------------------------------------------------------------------
  // Bypass is not modelled; its code shows the loop counter instead.
  sdcp_probe_e probe;
  logic test_d;

  assign probe = sdcp_probe_e'(cfg_t_q);
  always_comb begin
    unique case (probe)
      SDCP_PROBE_SR_LAST: test_d = sr_copy_q[`SDCP_SR_LAST];
      SDCP_PROBE_HIGH: test_d = 1'b1;
      SDCP_PROBE_FREF: test_d = fref_div;
      SDCP_PROBE_MCNT: test_d = mcnt_div;
      SDCP_PROBE_SYNTH_OUT: test_d = out_div;
      SDCP_PROBE_LOW: test_d = 1'b0;
      SDCP_PROBE_BYPASS: test_d = mcnt_div;
      SDCP_PROBE_SYNTH_OUT4: test_d = out4_div;
    endcase
  end

  // --------------------------------------------------------------------------
  // Output registers
  // --------------------------------------------------------------------------
  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_loop_div <= `SDCP_M_RST;
      o_out_sel <= `SDCP_N_RST;
      o_out_ratio <= 5'h00;
      o_probe_sel <= `SDCP_T_RST;
      o_fref <= 1'b0;
      o_synth_clock_out <= 1'b0;
      o_test <= 1'b0;
      o_synth_freq_khz <= '0;
    end else begin
      o_loop_div <= cfg_m_q;
      o_out_sel <= cfg_n_q;
      o_out_ratio <= out_ratio;
      o_probe_sel <= cfg_t_q;
      o_fref <= fref_div;
      o_synth_clock_out <= out_div;
      o_test <= test_d;
      o_synth_freq_khz <= freq_khz[FREQ_W-1:0];
    end
  end

endmodule

// >>> hdl/sdcp_defines.svh
`ifndef SDCP_DEFINES_SVH
`define SDCP_DEFINES_SVH

// ----------------------------------------------------------------------------
// Serial stream layout
// ----------------------------------------------------------------------------
// The first bit shifted in ends up in the top bit after a full load.
`define SDCP_SR_LEN 14
`define SDCP_T_HI 13
`define SDCP_T_LO 11
`define SDCP_N_HI 10
`define SDCP_N_LO 9
`define SDCP_M_HI 8
`define SDCP_M_LO 0
`define SDCP_SR_LAST 13

// ----------------------------------------------------------------------------
// Reset values and fixed ratios
// ----------------------------------------------------------------------------
`define SDCP_SR_RST 14'h0000
`define SDCP_M_RST 9'h000
`define SDCP_N_RST 2'h0
`define SDCP_T_RST 3'h0
`define SDCP_REF_PREDIV 9'h008
`define SDCP_OUT4_DIV 9'h004
`define SDCP_XTAL_KHZ 16000
`define SDCP_FREQ_W 24

`endif

// >>> hdl/sdcp_pkg.sv
package sdcp_pkg;

  // Loop divider modulus, output divider select and probe select fields.
  typedef logic [8:0] sdcp_m_t;
  typedef logic [1:0] sdcp_n_t;
  typedef logic [2:0] sdcp_t_t;

  // Nodes that the observation output can show.
  typedef enum logic [2:0] {
    SDCP_PROBE_SR_LAST = 3'h0,
    SDCP_PROBE_HIGH = 3'h1,
    SDCP_PROBE_FREF = 3'h2,
    SDCP_PROBE_MCNT = 3'h3,
    SDCP_PROBE_SYNTH_OUT = 3'h4,
    SDCP_PROBE_LOW = 3'h5,
    SDCP_PROBE_BYPASS = 3'h6,
    SDCP_PROBE_SYNTH_OUT4 = 3'h7
  } sdcp_probe_e;

endpackage

// >>> hdl/sdcp_div.sv
`timescale 1ns/1ns
// ----------------------------------------------------------------------------
// Programmable divider: high for the first half of each period.
// ----------------------------------------------------------------------------
module sdcp_div #(
  parameter int W = 9
) (
  input wire logic i_clk, // Counting clock.
  input wire logic i_rst, // Asynchronous reset, active high.
  input wire logic [W-1:0] i_ratio, // Divide ratio, used as given.
  output logic o_div // Divided output.
);

  logic [W-1:0] cnt_q;
  logic [W-1:0] cnt_d;
  logic [W-1:0] last;
  logic [W-1:0] half;
  logic wrap;
  logic div_d;

  // A ratio of zero wraps at the top of the counter; no value is rejected.
  assign last = i_ratio - {{(W-1){1'b0}}, 1'b1};
  assign half = i_ratio >> 1;
  assign wrap = (cnt_q >= last);
  assign cnt_d = wrap ? '0 : cnt_q + {{(W-1){1'b0}}, 1'b1};
  assign div_d = (cnt_d < half);

  // Counter and output register. The counter rests on its top count in
  // reset, so the first period after release is as long as every later one.
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      cnt_q <= '1;
      o_div <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      o_div <= div_d;
    end
  end

endmodule

// >>> tb/sdcp_top_chk.sv
`timescale 1ns/1ns
module sdcp_top_chk
  import sdcp_pkg::*;
#(
  parameter int XTAL_KHZ = 16000,
  parameter int FREQ_W = 24
) (
  input wire logic i_ref_clk, // Reference clock.
  input wire logic i_sys_rst, // Reset, active high.
  input wire logic i_serial_load, // Serial load strobe.
  input wire logic i_par_load_n, // Parallel load strobe.
  input wire sdcp_pkg::sdcp_m_t i_par_m, // Parallel loop value.
  input wire sdcp_pkg::sdcp_n_t i_par_n, // Parallel output select.
  input wire sdcp_pkg::sdcp_m_t o_loop_div, // Latched loop value.
  input wire sdcp_pkg::sdcp_n_t o_out_sel, // Latched output select.
  input wire logic [4:0] o_out_ratio, // Decoded ratio.
  input wire sdcp_pkg::sdcp_t_t o_probe_sel, // Latched probe select.
  input wire logic o_fref, // Comparison reference.
  input wire logic o_test, // Observation output.
  input wire logic [FREQ_W-1:0] o_synth_freq_khz // Nominal frequency.
);
  // All checks share the reference domain; windows of six cover the synchroniser latency.
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (i_sys_rst);
  chk_par_follow: assert property (
    (!i_par_load_n && $stable(i_par_m) && $stable(i_par_n))[*6] |-> o_loop_div == i_par_m && o_out_sel == i_par_n)
    else $error("parallel pins not followed");
  chk_probe_zero: assert property (!i_par_load_n[*6] |-> o_probe_sel == 3'h0)
    else $error("probe select not forced to zero");
  chk_cfg_hold: assert property (
    (i_par_load_n && !i_serial_load)[*6] |=> $stable(o_loop_div) && $stable(o_out_sel))
    else $error("divider values changed while closed");
  chk_probe_hold: assert property ((i_par_load_n && !i_serial_load)[*6] |=> $stable(o_probe_sel))
    else $error("probe select changed while closed");
  chk_fref_shape: assert property ($rose(o_fref) |->
    o_fref[*4] ##1 !o_fref[*4] ##1 o_fref) else $error("reference period wrong");
  chk_ratio_map: assert property (
    $stable(o_out_sel)[*2] ##0 o_out_ratio != 5'h0 |-> o_out_ratio == 5'h2 << o_out_sel)
    else $error("output ratio decode wrong");
  chk_freq_value: assert property (
    ($stable(o_loop_div) && $stable(o_out_sel))[*3] |->
    o_synth_freq_khz == FREQ_W'(((XTAL_KHZ / 8) * int'(o_loop_div)) >> (int'(o_out_sel) + 1)))
    else $error("frequency value wrong");
  chk_test_high: assert property ((o_probe_sel == 3'h1)[*3] |-> o_test)
    else $error("test output not high");
  chk_test_low: assert property ((o_probe_sel == 3'h5)[*3] |-> !o_test)
    else $error("test output not low");
  chk_test_fref: assert property ((o_probe_sel == 3'h2)[*3] |-> o_test == o_fref)
    else $error("test output not following reference");
  cover property (o_probe_sel == 3'h7);
  cover property (o_out_ratio == 5'h10);
  cover property ($fell(i_serial_load));
endmodule

// >>> tb/sdcp_host.sv
`timescale 1ns/1ns
module sdcp_host (
  output logic o_shift_clk, // Shift clock, still outside frames.
  output logic o_shift_data, // Serial data.
  output logic o_serial_load // Serial load strobe.
);
  // Idle levels at time zero.
  initial begin
    o_shift_clk = 1'h0;
    o_shift_data = 1'h0;
    o_serial_load = 1'h0;
  end
  // Shifts a word top bit first at a 160 ns period, then opens and closes the latches.
  task automatic send(input logic [13:0] w);
    #7;
    for (int i = 13; i >= 0; i--) begin
      o_shift_data = w[i];
      #80 o_shift_clk = 1'h1;
      #80 o_shift_clk = 1'h0;
    end
    o_shift_data = ~w[0]; // Hold time is over, so the line stops showing the bit.
    #400 o_serial_load = 1'h1;
    #800 o_serial_load = 1'h0;
    #400;
  endtask
endmodule

// >>> tb/tb.sv
`timescale 1ns/1ns
module tb;
  import sdcp_pkg::*;
  logic i_ref_clk = 1'h0;
  logic i_sys_rst = 1'h1;
  logic i_par_load_n = 1'h0;
  sdcp_m_t i_par_m = 9'h000;
  sdcp_n_t i_par_n = 2'h0;
  logic shift_clk, shift_data, serial_load, o_fref, o_synth_clock_out, o_test;
  sdcp_m_t o_loop_div;
  sdcp_n_t o_out_sel;
  logic [4:0] o_out_ratio;
  sdcp_t_t o_probe_sel;
  logic [23:0] o_synth_freq_khz, c;
  int n_errors = 0;
  int checked = 0;
  int cyc = 0;
  // Reference clock, 50 ns period.
  always #25 i_ref_clk = ~i_ref_clk;
  sdcp_host i_sdcp_host (.o_shift_clk(shift_clk), .o_shift_data(shift_data), .o_serial_load(serial_load));
  sdcp_top i_sdcp_top (.i_ref_clk(i_ref_clk), .i_sys_rst(i_sys_rst), .i_shift_clk(shift_clk),
    .i_shift_data(shift_data), .i_serial_load(serial_load), .i_par_load_n(i_par_load_n), .i_par_m(i_par_m),
    .i_par_n(i_par_n), .o_loop_div(o_loop_div), .o_out_sel(o_out_sel), .o_out_ratio(o_out_ratio),
    .o_probe_sel(o_probe_sel), .o_fref(o_fref), .o_synth_clock_out(o_synth_clock_out), .o_test(o_test),
    .o_synth_freq_khz(o_synth_freq_khz));
  task automatic wrap_up;
    $display("checks %0d errors %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic cmp(input string what, input logic [23:0] exp, input logic [23:0] got);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wait_cyc(input int n);
    repeat (n) @(negedge i_ref_clk);
  endtask
  // Expected frequency is 2000 kHz times the loop value over the output ratio.
  task automatic chk_cfg(input sdcp_m_t m, input sdcp_n_t n, input sdcp_t_t t);
    cmp("loop_div", 24'(m), 24'(o_loop_div));
    cmp("out_sel", 24'(n), 24'(o_out_sel));
    cmp("out_ratio", 24'h00_0002 << n, 24'(o_out_ratio));
    cmp("probe_sel", 24'(t), 24'(o_probe_sel));
    cmp("freq_khz", (24'h00_07d0 * 24'(m)) >> (32'(n) + 1), o_synth_freq_khz);
  endtask
  // Counts reference cycles from one rise of the chosen clock to the next.
  task automatic period(input logic f, output logic [23:0] k);
    logic p, s;
    int r;
    k = 24'h00_0000;
    r = 0;
    p = 1'h1;
    while (r < 2) begin
      @(negedge i_ref_clk);
      s = f ? o_fref : o_synth_clock_out;
      if (s && !p) r++;
      if (r == 1) k++;
      p = s;
    end
  endtask
  // A hung wait still reaches the verdict.
  always @(posedge i_ref_clk) begin
    cyc++;
    if (cyc == 5000) begin
      n_errors++;
      wrap_up;
    end
  end
  // Parallel loads for every output select, then serial loads for every probe code.
  initial begin
    wait_cyc(4);
    i_sys_rst = 1'h0;
    for (int n = 0; n < 4; n++) begin
      i_par_load_n = 1'h0;
      i_par_m = 9'h0c8 + 9'(n);
      i_par_n = 2'(n);
      wait_cyc(6);
      chk_cfg(i_par_m, i_par_n, 3'h0);
      period(1'h0, c);
      cmp("clk_out_period", 24'h00_0002 << n, c);
      i_par_load_n = 1'h1;
      wait_cyc(4);
      i_par_m = ~i_par_m;
      i_par_n = ~i_par_n;
      wait_cyc(6);
      chk_cfg(9'h0c8 + 9'(n), 2'(n), 3'h0);
    end
    period(1'h1, c);
    cmp("fref_period", 24'h00_0008, c);
    $display("test parallel done");
    for (int t = 0; t < 8; t++) begin
      i_sdcp_host.send({3'(t), 2'(t), 9'h1f8 + 9'(t)});
      wait_cyc(1);
      chk_cfg(9'h1f8 + 9'(t), 2'(t), 3'(t));
      if (t == 0 || t == 1 || t == 5) cmp("test_pin", 24'(t == 1), 24'(o_test));
    end
    i_par_load_n = 1'h0;
    i_par_m = 9'h011;
    i_par_n = 2'h2;
    i_sdcp_host.send(14'h3fff);
    wait_cyc(1);
    chk_cfg(9'h011, 2'h2, 3'h0);
    $display("test serial done");
    wrap_up;
  end
endmodule
bind sdcp_top sdcp_top_chk #(.XTAL_KHZ(XTAL_KHZ), .FREQ_W(FREQ_W)) i_chk (.i_ref_clk(i_ref_clk),
  .i_sys_rst(i_sys_rst), .i_serial_load(i_serial_load), .i_par_load_n(i_par_load_n), .i_par_m(i_par_m),
  .i_par_n(i_par_n), .o_loop_div(o_loop_div), .o_out_sel(o_out_sel), .o_out_ratio(o_out_ratio),
  .o_probe_sel(o_probe_sel), .o_fref(o_fref), .o_test(o_test), .o_synth_freq_khz(o_synth_freq_khz));
